// *** inc/cbsm_consts.svh ***
`ifndef CBSM_CONSTS_SVH
`define CBSM_CONSTS_SVH

// Clock and time base
`define CBSM_CLK_NS 5
`define CBSM_TICK_NS 1000000

// Register byte addresses
`define CBSM_ADDR_CTRL 12'h000
`define CBSM_ADDR_WDCLR 12'h004
`define CBSM_ADDR_STAT 12'h008

// Register fields (control, watchdog clear, status)
`define CBSM_F_MODE 3:0
`define CBSM_F_WDEN 4
`define CBSM_F_PWRCUT 5
`define CBSM_F_IFC 13:8
`define CBSM_F_FCT 19:16
`define CBSM_F_TOT 23:20
`define CBSM_F_WDCLR 1:0
`define CBSM_F_DET 3:0
`define CBSM_F_OK 4
`define CBSM_F_STATE 11:8

// Reset values and keys
`define CBSM_MODE_DEFAULT 4'h4
`define CBSM_MODE_CHARGE 4'h5
`define CBSM_IFC_DEFAULT 6'h10
`define CBSM_FCT_DEFAULT 4'h3
`define CBSM_TOT_DEFAULT 4'h3
`define CBSM_WDCLR_KEY 2'h1

// Detail codes
`define CBSM_DET_PREQ 4'h0
`define CBSM_DET_CC 4'h1
`define CBSM_DET_CV 4'h2
`define CBSM_DET_TOPOFF 4'h3
`define CBSM_DET_DONE 4'h4
`define CBSM_DET_TFAULT 4'h6
`define CBSM_DET_IDLE 4'h8
`define CBSM_DET_SHUTDOWN_TEMPERATURE 4'hA
`define CBSM_DET_WDEXP 4'hB

// Times in milliseconds (one tick each)
`define CBSM_REPORT_MS 32'h0000_0010
`define CBSM_PQ_MS 32'h001B_7740
`define CBSM_TERM_MS 32'h0000_001E
`define CBSM_WD_MS 32'h0000_07D0
`define CBSM_PWRCUT_MS 32'h0000_0096
`define CBSM_FC_UNIT_MS 32'h0036_EE80
`define CBSM_TO_UNIT_MS 32'h0009_27C0

`endif

// *** inc/cbsm_pkg.sv ***
`include "cbsm_consts.svh"

package cbsm_pkg;

    typedef enum logic [3:0] {
        CBSM_IDLE    = 4'h0,
        CBSM_PRECHG  = 4'h1,
        CBSM_TRICKLE = 4'h3,
        CBSM_CC      = 4'h2,
        CBSM_CV      = 4'h6,
        CBSM_TOPOFF  = 4'h7,
        CBSM_DONE    = 4'h5,
        CBSM_TFAULT  = 4'h4,
        CBSM_WDSUSP  = 4'hC,
        CBSM_SHUTDOWN_TEMPERATURE   = 4'hD,
        CBSM_PWRCUT  = 4'hF
    } cbsm_state_t;

    typedef struct packed {
        cbsm_state_t st;
        logic [31:0] tick_cnt;
        logic [31:0] tmr;
        logic [31:0] fc_cnt;
        logic [31:0] term_cnt;
        logic [31:0] rpt_cnt;
        logic [31:0] wd_cnt;
        logic rpt_done;
        logic [3:0] mode;
        logic wd_en;
        logic pwrcut;
        logic [5:0] fast_charge_current;
        logic [3:0] fct;
        logic [3:0] tot;
        logic mode_off_seen;
        logic ok;
        logic [3:0] detail;
        logic irq;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [31:0] prdata;
    } cbsm_regs_t;

endpackage : cbsm_pkg

// *** core/cbsm_core.sv ***
// Function
// (R1) Fast charge CC between low and regulation thresholds; report ok, code 0x01.
// (R2) CC current never exceeds programmed fast-charge current.
// (R3) Battery above regulation threshold in CC advances to CV.
// (R4) Combined CC plus CV time over programmed limit gives timer fault.
// (R5) Each prequalification state over its dwell limit gives timer fault.
// (R6) Unserviced watchdog in any charging state goes to watchdog suspend.
// (R7) Die above regulation temperature reduces fast-charge current.
// (R8) CV holds regulation; after delay report ok, code 0x02.
// (R9) Current below top-off threshold for qualify time in CV enters top-off.
// (R10) Top-off only from CV; after delay report ok, code 0x03.
// (R11) Top-off duration elapsed advances to done.
// (R12) Battery below regulation minus margin in top-off or done returns to CC.
// (R13) Done has zero current; after delay code 0x04, ok cleared.
// (R14) Timer fault entry: immediate interrupt, ok cleared, code 0x06, charger off.
// (R15) Timer fault left by mode off then on, or input removal.
// (R16) Watchdog disabled after reset; counts only when enable bit set.
// (R17) Host writes 0x01 to watchdog clear within each period.
// (R18) Expiry without power cut: stop, clear ok, report code; 0x01 restarts.
// (R19) Expiry with power cut: all off for 150ms, then registers reset.
// (R20) Shutdown temperature forces thermal shutdown, code 0x0A, charging stops.
// (R21) Thermal shutdown resets mode field and control register to defaults; the code keeps the watchdog enable and power-cut bits.
// (R22) Prequalification below dead-battery threshold; after delay ok, code 0x00.
// (R23) Mode 0x05 charges with buck on; other modes keep charger off.
// (R24) Report delay restarts on each state entry; reports only after it completes.
// (R25) Watchdog-expired detail code is distinct from all other codes.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "cbsm_consts.svh"

module cbsm_core #(
    parameter int TICK_CYCLES = `CBSM_TICK_NS / `CBSM_CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic vbat_over_dead,
    input wire logic vbat_over_low,
    input wire logic vbat_over_reg,
    input wire logic vbat_below_restart,
    input wire logic ichg_below_topoff,
    input wire logic die_over_regulation,
    input wire logic die_over_shutdown,
    input wire logic charger_input_valid,
    output logic charger_on,
    output logic buck_on,
    output logic battery_system_switch,
    output logic [5:0] charge_current,
    output cbsm_pkg::cbsm_state_t charger_state,
    output logic charger_state_irq,
    output logic charger_good_flag,
    output logic [3:0] charger_detail_code
);
    import cbsm_pkg::*;

    cbsm_regs_t s;
    cbsm_regs_t next_s;
    logic tick;
    logic wr;
    logic rd_setup;
    logic wdclr;
    logic wd_exp;
    logic mapped;
    logic mode_off_wr;
    logic s_dead;
    logic s_low;
    logic s_reg;
    logic s_restart;
    logic s_below_to;
    logic s_die_hot;
    logic s_shdn;
    logic s_input;

    function automatic logic is_charging(input cbsm_state_t st);
        return st inside {CBSM_PRECHG, CBSM_TRICKLE, CBSM_CC, CBSM_CV, CBSM_TOPOFF};
    endfunction : is_charging

    function automatic logic is_fast(input cbsm_state_t st);
        return st inside {CBSM_CC, CBSM_CV};
    endfunction : is_fast

    assign {s_dead, s_low, s_reg, s_restart} = s.sync2[7:4];
    assign {s_below_to, s_die_hot, s_shdn, s_input} = s.sync2[3:0];
    // One-cycle time base; every dwell limit counts these
    assign tick = (s.tick_cnt == 32'(TICK_CYCLES - 1));
    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped = paddr inside {`CBSM_ADDR_CTRL, `CBSM_ADDR_WDCLR, `CBSM_ADDR_STAT};
    assign wdclr = wr && paddr == `CBSM_ADDR_WDCLR && pwdata[`CBSM_F_WDCLR] == `CBSM_WDCLR_KEY;
    // Saturated count keeps expiry asserted until a clear
    assign wd_exp = s.wd_en && s.wd_cnt >= `CBSM_WD_MS;
    assign mode_off_wr = wr && paddr == `CBSM_ADDR_CTRL &&
                         pwdata[`CBSM_F_MODE] != `CBSM_MODE_CHARGE;

    always_comb begin
        next_s = s;
        next_s.irq = 1'b0;
        // First stage feeds only the second stage
        next_s.sync1 = {vbat_over_dead, vbat_over_low, vbat_over_reg, vbat_below_restart,
                        ichg_below_topoff, die_over_regulation, die_over_shutdown,
                        charger_input_valid};
        next_s.sync2 = s.sync1;
        next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;

        if (wr && paddr == `CBSM_ADDR_CTRL) begin
            next_s.mode = pwdata[`CBSM_F_MODE];
            next_s.wd_en = pwdata[`CBSM_F_WDEN];
            next_s.pwrcut = pwdata[`CBSM_F_PWRCUT];
            next_s.fast_charge_current = pwdata[`CBSM_F_IFC];
            next_s.fct = pwdata[`CBSM_F_FCT];
            next_s.tot = pwdata[`CBSM_F_TOT];
            if (mode_off_wr) begin
                next_s.mode_off_seen = 1'b1; // [R15]
            end
        end

        if (rd_setup) begin
            next_s.prdata = 32'h0;
            if (paddr == `CBSM_ADDR_CTRL) begin
                next_s.prdata[`CBSM_F_MODE] = s.mode;
                next_s.prdata[`CBSM_F_WDEN] = s.wd_en;
                next_s.prdata[`CBSM_F_PWRCUT] = s.pwrcut;
                next_s.prdata[`CBSM_F_IFC] = s.fast_charge_current;
                next_s.prdata[`CBSM_F_FCT] = s.fct;
                next_s.prdata[`CBSM_F_TOT] = s.tot;
            end else if (paddr == `CBSM_ADDR_STAT) begin
                next_s.prdata[`CBSM_F_DET] = s.detail;
                next_s.prdata[`CBSM_F_OK] = s.ok;
                next_s.prdata[`CBSM_F_STATE] = s.st;
            end
        end

        // Watchdog: held at zero while disabled, saturates at expiry
        if (!s.wd_en || wdclr) begin
            next_s.wd_cnt = 32'h0; // [R16] [R17]
        end else if (tick && !wd_exp) begin
            next_s.wd_cnt = s.wd_cnt + 32'h1;
        end

        if (tick) begin
            next_s.tmr = s.tmr + 32'h1;
            if (s.rpt_cnt < `CBSM_REPORT_MS) begin
                next_s.rpt_cnt = s.rpt_cnt + 32'h1;
            end
            if (is_fast(s.st)) begin
                next_s.fc_cnt = s.fc_cnt + 32'h1; // [R4]
            end
        end
        // Any high-current sample restarts qualification
        if (s.st != CBSM_CV || !s_below_to) begin
            next_s.term_cnt = 32'h0;
        end else if (tick) begin
            next_s.term_cnt = s.term_cnt + 32'h1; // [R9]
        end

        // Thermal trip outranks every other exit
        if (s_shdn && s.st != CBSM_SHUTDOWN_TEMPERATURE) begin
            next_s.st = CBSM_SHUTDOWN_TEMPERATURE; // [R20]
            next_s.irq = s.ok;
            next_s.ok = 1'b0;
            next_s.detail = `CBSM_DET_SHUTDOWN_TEMPERATURE;
            next_s.mode = `CBSM_MODE_DEFAULT; // [R21]
            next_s.fast_charge_current = `CBSM_IFC_DEFAULT;
            next_s.fct = `CBSM_FCT_DEFAULT;
            next_s.tot = `CBSM_TOT_DEFAULT;
        end else if ((is_charging(s.st) || s.st inside {CBSM_DONE, CBSM_TFAULT}) && wd_exp) begin
            next_s.irq = s.ok; // [R6] [R18]
            next_s.ok = 1'b0;
            next_s.detail = `CBSM_DET_WDEXP; // [R25]
            next_s.st = s.pwrcut ? CBSM_PWRCUT : CBSM_WDSUSP; // [R19]
        end else begin
            unique case (s.st)
                CBSM_IDLE: begin
                    next_s.detail = `CBSM_DET_IDLE;
                    if (s_input && s.mode == `CBSM_MODE_CHARGE) begin
                        next_s.st = CBSM_PRECHG; // [R23]
                    end
                end
                CBSM_SHUTDOWN_TEMPERATURE: begin
                    if (!s_shdn) begin
                        next_s.st = CBSM_IDLE;
                    end
                end
                // Comes back as a fresh power-up once the cut ends
                CBSM_PWRCUT: begin
                    if (s.tmr >= `CBSM_PWRCUT_MS) begin
                        next_s.st = CBSM_IDLE; // [R19]
                        next_s.mode = `CBSM_MODE_DEFAULT;
                        next_s.wd_en = 1'b0;
                        next_s.pwrcut = 1'b0;
                        next_s.fast_charge_current = `CBSM_IFC_DEFAULT;
                        next_s.fct = `CBSM_FCT_DEFAULT;
                        next_s.tot = `CBSM_TOT_DEFAULT;
                        next_s.wd_cnt = 32'h0;
                        next_s.ok = 1'b0;
                        next_s.detail = `CBSM_DET_IDLE;
                    end
                end
                CBSM_WDSUSP: begin
                    if (wdclr || !s_input) begin
                        next_s.st = CBSM_IDLE; // [R18]
                    end
                end
                CBSM_TFAULT: begin
                    if (!s_input || (s.mode == `CBSM_MODE_CHARGE && s.mode_off_seen)) begin
                        next_s.st = CBSM_IDLE; // [R15]
                    end
                end
                CBSM_PRECHG, CBSM_TRICKLE, CBSM_CC, CBSM_CV, CBSM_TOPOFF, CBSM_DONE: begin
                    if (!s_input || s.mode != `CBSM_MODE_CHARGE) begin
                        next_s.st = CBSM_IDLE;
                    end else begin
                        unique case (s.st)
                            CBSM_PRECHG: begin
                                if (s.tmr >= `CBSM_PQ_MS) begin
                                    next_s.st = CBSM_TFAULT; // [R5]
                                end else if (s_dead) begin
                                    next_s.st = CBSM_TRICKLE;
                                end
                            end
                            CBSM_TRICKLE: begin
                                if (s.tmr >= `CBSM_PQ_MS) begin
                                    next_s.st = CBSM_TFAULT; // [R5]
                                end else if (s_low) begin
                                    next_s.st = CBSM_CC;
                                end
                            end
                            CBSM_CC: begin
                                if (s.fc_cnt >= 32'(s.fct) * `CBSM_FC_UNIT_MS) begin
                                    next_s.st = CBSM_TFAULT; // [R4]
                                end else if (s_reg) begin
                                    next_s.st = CBSM_CV; // [R3]
                                end
                            end
                            CBSM_CV: begin
                                if (s.fc_cnt >= 32'(s.fct) * `CBSM_FC_UNIT_MS) begin
                                    next_s.st = CBSM_TFAULT; // [R4]
                                end else if (s.term_cnt >= `CBSM_TERM_MS) begin
                                    next_s.st = CBSM_TOPOFF; // [R9] [R10]
                                end
                            end
                            CBSM_TOPOFF: begin
                                if (s_restart) begin
                                    next_s.st = CBSM_CC; // [R12]
                                end else if (s.tmr >= 32'(s.tot) * `CBSM_TO_UNIT_MS) begin
                                    next_s.st = CBSM_DONE; // [R11]
                                end
                            end
                            default: begin
                                if (s_restart) begin
                                    next_s.st = CBSM_CC; // [R12]
                                end
                            end
                        endcase
                    end
                end
                default: next_s.st = CBSM_IDLE;
            endcase
        end

        // Delayed status report of the settled state
        // A report that coincides with an exit is dropped, not applied to the new state
        if (!s.rpt_done && s.rpt_cnt >= `CBSM_REPORT_MS && next_s.st == s.st) begin // [R24]
            next_s.rpt_done = 1'b1;
            unique case (s.st)
                CBSM_PRECHG, CBSM_TRICKLE, CBSM_CC, CBSM_CV, CBSM_TOPOFF: begin
                    next_s.irq = !s.ok; // [R1] [R8] [R10] [R22]
                    next_s.ok = 1'b1;
                    unique case (s.st)
                        CBSM_CC: next_s.detail = `CBSM_DET_CC;
                        CBSM_CV: next_s.detail = `CBSM_DET_CV;
                        CBSM_TOPOFF: next_s.detail = `CBSM_DET_TOPOFF;
                        default: next_s.detail = `CBSM_DET_PREQ;
                    endcase
                end
                CBSM_DONE: begin
                    next_s.irq = !s.ok; // [R13]
                    next_s.ok = 1'b0;
                    next_s.detail = `CBSM_DET_DONE;
                end
                default: begin
                end
            endcase
        end

        if (next_s.st == CBSM_TFAULT && s.st != CBSM_TFAULT) begin
            next_s.irq = 1'b1; // [R14]
            next_s.ok = 1'b0;
            next_s.detail = `CBSM_DET_TFAULT;
            // An off write landing in the entry cycle still arms the exit
            next_s.mode_off_seen = mode_off_wr; // [R15]
        end

        // Every state entry restarts its timers, save the fast-charge count, which runs on from CC into CV
        if (next_s.st != s.st) begin
            next_s.tmr = 32'h0;
            next_s.rpt_cnt = 32'h0; // [R24]
            next_s.rpt_done = 1'b0;
            if (!is_fast(s.st)) begin
                next_s.fc_cnt = 32'h0; // [R4]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= CBSM_IDLE;
            s.mode <= `CBSM_MODE_DEFAULT;
            s.fast_charge_current <= `CBSM_IFC_DEFAULT;
            s.fct <= `CBSM_FCT_DEFAULT;
            s.tot <= `CBSM_TOT_DEFAULT;
            s.detail <= `CBSM_DET_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = s.prdata;

    // Top-off still charges; done and the fault states draw nothing
    assign charger_on = is_charging(s.st); // [R14] [R20]
    assign buck_on = s.st != CBSM_PWRCUT; // [R19]
    assign battery_system_switch = s.st != CBSM_PWRCUT;
    // Halving is a coarse stand-in for the analog foldback loop
    assign charge_current = !is_charging(s.st) ? 6'h0 :
                            s_die_hot ? {1'b0, s.fast_charge_current[5:1]} : s.fast_charge_current; // [R2] [R7] [R13]
    assign charger_state = s.st;
    assign charger_state_irq = s.irq;
    assign charger_good_flag = s.ok;
    assign charger_detail_code = s.detail;

endmodule : cbsm_core

// *** dv/cbsm_chk.sv ***
`timescale 1ns/10ps
module cbsm_chk #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic die_over_shutdown,
    input wire logic charger_on,
    input wire logic buck_on,
    input wire logic battery_system_switch,
    input wire logic [5:0] charge_current,
    input wire cbsm_pkg::cbsm_state_t charger_state,
    input wire logic charger_state_irq,
    input wire logic charger_good_flag,
    input wire logic [3:0] charger_detail_code
);
    import cbsm_pkg::*;
    // Free-running tick phase allows up to one tick of slack
    localparam int MIN_DW = 15 * TICK_CYCLES;
    cbsm_state_t prev;
    logic [31:0] dwell;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= CBSM_IDLE;
            dwell <= 32'h0000_0000;
        end else begin
            prev <= charger_state;
            dwell <= (charger_state != prev) ? 32'h0000_0001 : dwell + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_tfault_entry: assert property ($changed(charger_state) && charger_state == CBSM_TFAULT
        |-> charger_state_irq && !charger_good_flag && charger_detail_code == 4'h6 && !charger_on)
        else $error("timer fault entry wrong");
    a_cv_from_cc: assert property ($changed(charger_state) && charger_state == CBSM_CV
        |-> $past(charger_state) == CBSM_CC) else $error("cv entered not from cc");
    a_topoff_from_cv: assert property ($changed(charger_state) && charger_state == CBSM_TOPOFF
        |-> $past(charger_state) == CBSM_CV) else $error("top-off entered not from cv");
    a_report_wait: assert property (charger_state_irq && charger_state inside
        {CBSM_PRECHG, CBSM_TRICKLE, CBSM_CC, CBSM_CV, CBSM_TOPOFF, CBSM_DONE}
        |-> dwell >= MIN_DW) else $error("report before delay");
    a_irq_ok_rise: assert property (charger_state_irq && charger_state inside
        {CBSM_CC, CBSM_CV, CBSM_TOPOFF} |-> charger_good_flag && !$past(charger_good_flag))
        else $error("charge report irq wrong");
    a_done_report: assert property (charger_state_irq && charger_state == CBSM_DONE
        |-> !charger_good_flag && charger_detail_code == 4'h4 && charge_current == 6'h00)
        else $error("done report wrong");
    a_shutdown_temperature_force: assert property (die_over_shutdown [*4] |=> charger_state == CBSM_SHUTDOWN_TEMPERATURE)
        else $error("no thermal shutdown");
    a_shutdown_temperature_code: assert property (charger_state == CBSM_SHUTDOWN_TEMPERATURE
        |-> !charger_good_flag && charger_detail_code == 4'hA && !charger_on)
        else $error("thermal shutdown status wrong");
    a_wdsusp_code: assert property (charger_state == CBSM_WDSUSP
        |-> charger_detail_code == 4'hB && !charger_good_flag && !charger_on)
        else $error("watchdog suspend status wrong");
    a_pwrcut_off: assert property (charger_state == CBSM_PWRCUT
        |-> !buck_on && !battery_system_switch && !charger_on) else $error("power cut not off");
    a_idle_current: assert property (charger_state inside {CBSM_IDLE,
        CBSM_DONE, CBSM_TFAULT, CBSM_WDSUSP, CBSM_SHUTDOWN_TEMPERATURE, CBSM_PWRCUT}
        |-> !charger_on && charge_current == 6'h00)
        else $error("current while charger off");
endmodule : cbsm_chk

// *** dv/cbsm_batt_model.sv ***
`timescale 1ns/10ps
module cbsm_batt_model (
    input wire logic [2:0] level,
    output logic vbat_over_dead,
    output logic vbat_over_low,
    output logic vbat_over_reg,
    output logic vbat_below_restart,
    output logic ichg_below_topoff
);
    // Level 0 dead, 1 low, 2 fast, 3 at regulation, 4 tapering current
    assign vbat_over_dead = level > 3'h0;
    assign vbat_over_low = level > 3'h1;
    assign vbat_over_reg = level > 3'h2;
    assign vbat_below_restart = level < 3'h3;
    assign ichg_below_topoff = level == 3'h4;
endmodule : cbsm_batt_model

// *** dv/cbsm_tb_top.sv ***
`timescale 1ns/10ps
module cbsm_tb_top;
    import cbsm_pkg::*;
    localparam int TICK = 4;
    localparam int RPT = 16 * TICK + 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, err;
    logic [2:0] level = 3'h0;
    logic die_over_regulation = 1'b0;
    logic die_over_shutdown = 1'b0;
    logic charger_input_valid = 1'b1;
    logic vbat_over_dead, vbat_over_low, vbat_over_reg, vbat_below_restart, ichg_below_topoff;
    logic charger_on, buck_on, battery_system_switch, charger_state_irq, charger_good_flag;
    logic [5:0] charge_current, fast_charge_current;
    logic [3:0] charger_detail_code, offm;
    cbsm_state_t charger_state;
    logic [31:0] rd;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2.5 pclk = ~pclk;
    cbsm_core #(.TICK_CYCLES(TICK)) cbsm_core_inst (.*);
    cbsm_batt_model cbsm_batt_model_inst (.*);
    function automatic logic [31:0] ctrl_w(logic [3:0] m, logic wd, logic pc, logic [5:0] i,
        logic [3:0] f, logic [3:0] t);
        return {8'h00, t, f, 2'b00, i, 2'b00, pc, wd, m};
    endfunction : ctrl_w
    function automatic logic [31:0] stat_w(cbsm_state_t s, logic k, logic [3:0] d);
        return {20'h0_0000, s, 3'b000, k, d};
    endfunction : stat_w
    function automatic logic [5:0] exp_cur(logic [5:0] i, logic hot);
        return hot ? (i >> 1) : i;
    endfunction : exp_cur
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdchk
    task automatic wait_st(input cbsm_state_t s, input int lim);
        for (int i = 0; i < lim && charger_state !== s; i++) @(posedge pclk);
        chk(charger_state, s);
    endtask : wait_st
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        void'($urandom(32'hBEF2EFE9));
        fast_charge_current = 6'($urandom_range(63, 1));
        offm = $urandom_range(1, 0) ? 4'h4 : 4'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(12'h000, ctrl_w(4'h4, 1'b0, 1'b0, 6'h10, 4'h3, 4'h3));
        rdchk(12'h008, stat_w(CBSM_IDLE, 1'b0, 4'h8));
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 12'h000, ctrl_w(4'h5, 1'b0, 1'b0, fast_charge_current, 4'h1, 4'h0));
        wait_st(CBSM_PRECHG, 10);
        repeat (RPT) @(posedge pclk);
        rdchk(12'h008, stat_w(CBSM_PRECHG, 1'b1, 4'h0));
        level <= 3'h1;
        wait_st(CBSM_TRICKLE, 10);
        level <= 3'h2;
        wait_st(CBSM_CC, 10);
        repeat (4) @(posedge pclk);
        chk(charge_current, exp_cur(fast_charge_current, 1'b0));
        die_over_regulation <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(charge_current, exp_cur(fast_charge_current, 1'b1));
        die_over_regulation <= 1'b0;
        repeat (RPT) @(posedge pclk);
        rdchk(12'h008, stat_w(CBSM_CC, 1'b1, 4'h1));
        level <= 3'h3;
        wait_st(CBSM_CV, 10);
        repeat (RPT) @(posedge pclk);
        rdchk(12'h008, stat_w(CBSM_CV, 1'b1, 4'h2));
        level <= 3'h4;
        wait_st(CBSM_TOPOFF, 30 * TICK + 20);
        wait_st(CBSM_DONE, 20);
        repeat (RPT) @(posedge pclk);
        rdchk(12'h008, stat_w(CBSM_DONE, 1'b0, 4'h4));
        level <= 3'h2;
        wait_st(CBSM_CC, 10);
        apb(1'b1, 12'h000, ctrl_w(4'h5, 1'b0, 1'b0, fast_charge_current, 4'h0, 4'h0));
        wait_st(CBSM_TFAULT, 10);
        rdchk(12'h008, stat_w(CBSM_TFAULT, 1'b0, 4'h6));
        apb(1'b1, 12'h000, ctrl_w(offm, 1'b0, 1'b0, fast_charge_current, 4'h1, 4'h0));
        apb(1'b1, 12'h000, ctrl_w(4'h5, 1'b0, 1'b0, fast_charge_current, 4'h1, 4'h0));
        wait_st(CBSM_CC, 20);
        // Serviced three times, then left to expire
        apb(1'b1, 12'h000, ctrl_w(4'h5, 1'b1, 1'b0, fast_charge_current, 4'h1, 4'h0));
        repeat (3) begin
            repeat (1500 * TICK) @(posedge pclk);
            apb(1'b1, 12'h004, 32'h0000_0001);
        end
        chk(charger_state, CBSM_CC);
        wait_st(CBSM_WDSUSP, 2000 * TICK + 20);
        rdchk(12'h008, stat_w(CBSM_WDSUSP, 1'b0, 4'hB));
        apb(1'b1, 12'h004, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk(charger_state, CBSM_WDSUSP);
        apb(1'b1, 12'h004, 32'h0000_0001);
        wait_st(CBSM_CC, 20);
        apb(1'b1, 12'h000, ctrl_w(4'h5, 1'b1, 1'b1, fast_charge_current, 4'h1, 4'h0));
        wait_st(CBSM_PWRCUT, 2000 * TICK + 20);
        chk(buck_on, 1'b0);
        chk(battery_system_switch, 1'b0);
        chk(charger_on, 1'b0);
        wait_st(CBSM_IDLE, 150 * TICK + 20);
        rdchk(12'h000, ctrl_w(4'h4, 1'b0, 1'b0, 6'h10, 4'h3, 4'h3));
        apb(1'b1, 12'h000, ctrl_w(4'h5, 1'b0, 1'b0, fast_charge_current, 4'h1, 4'h0));
        wait_st(CBSM_CC, 20);
        repeat (RPT) @(posedge pclk);
        die_over_shutdown <= 1'b1;
        wait_st(CBSM_SHUTDOWN_TEMPERATURE, 10);
        rdchk(12'h008, stat_w(CBSM_SHUTDOWN_TEMPERATURE, 1'b0, 4'hA));
        rdchk(12'h000, ctrl_w(4'h4, 1'b0, 1'b0, 6'h10, 4'h3, 4'h3));
        die_over_shutdown <= 1'b0;
        wait_st(CBSM_IDLE, 10);
        final_report();
    end
endmodule : cbsm_tb_top

bind cbsm_core cbsm_chk #(.TICK_CYCLES(TICK_CYCLES)) cbsm_chk_inst (.*);
